//--- hw/fvp_pkg.sv
package fvp_pkg;

	localparam int          FW        = 16;
	localparam int          AXI_AW    = 8;
	localparam int          AXI_DW    = 32;
	localparam int          NREG      = 24;
	localparam int          IXW       = 5;
	localparam int          IX_LSB    = 2;

	// register indexes; byte address is index times four
	localparam logic [4:0]  IX_MAXF   = 5'h00;
	localparam logic [4:0]  IX_MINF   = 5'h01;
	localparam logic [4:0]  IX_JOGF   = 5'h02;
	localparam logic [4:0]  IX_STARTF = 5'h03;
	localparam logic [4:0]  IX_JMP1A  = 5'h04;
	localparam logic [4:0]  IX_JMP1B  = 5'h05;
	localparam logic [4:0]  IX_JMP2A  = 5'h06;
	localparam logic [4:0]  IX_JMP2B  = 5'h07;
	localparam logic [4:0]  IX_JMP3A  = 5'h08;
	localparam logic [4:0]  IX_JMP3B  = 5'h09;
	localparam logic [4:0]  IX_BASEF  = 5'h0A;
	localparam logic [4:0]  IX_BASEV  = 5'h0B;
	localparam logic [4:0]  IX_BASE2F = 5'h0C;
	localparam logic [4:0]  IX_LOADP  = 5'h0D;
	localparam logic [4:0]  IX_BOOST  = 5'h0E;
	localparam logic [4:0]  IX_BOOST2 = 5'h0F;
	localparam logic [4:0]  IX_UGRP   = 5'h10;
	localparam logic [4:0]  IX_CTRL   = 5'h11;
	localparam logic [4:0]  IX_RATEDV = 5'h12;
	localparam logic [4:0]  IX_RATEDF = 5'h13;
	localparam logic [4:0]  IX_ASTEP  = 5'h14;
	localparam logic [4:0]  IX_STFREQ = 5'h15;
	localparam logic [4:0]  IX_STVOLT = 5'h16;
	localparam logic [4:0]  IX_STFLAG = 5'h17;

	// frequencies in 0.1 Hz, voltages in 1 V, boost in 0.1 %
	localparam logic [15:0] CODE_OFF  = 16'h270F;
	localparam logic [15:0] CODE_95   = 16'h22B8;
	localparam logic [15:0] FREQ_LIM  = 16'h0FA0;
	localparam logic [15:0] LIMF_LIM  = 16'h04B0;
	localparam logic [15:0] VOLT_LIM  = 16'h03E8;
	localparam logic [15:0] BOOST_LIM = 16'h012C;
	localparam logic [15:0] PCT_95    = 16'h005F;
	localparam logic [15:0] PCT_DIV   = 16'h0064;

	localparam logic [1:0]  LP_CONST  = 2'h0;
	localparam logic [1:0]  LP_VAR    = 2'h1;
	localparam logic [1:0]  LP_LIFTF  = 2'h2;
	localparam logic [1:0]  LP_LIFTR  = 2'h3;

	localparam int          MODE_LSB  = 0;
	localparam int          APAT_LSB  = 2;
	localparam logic [1:0]  MODE_VF   = 2'h0;
	localparam logic [1:0]  APAT_S_A  = 2'h1;
	localparam logic [15:0] CTRL_MASK = 16'h000F;

	localparam int          QSH       = 10;
	localparam int          CLK_NS    = 10;
	localparam int          UPD_NS    = 1000;
	localparam int          UPD_CYC   = UPD_NS / CLK_NS;
	localparam int          TCW       = 7;

	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_SLV  = 2'h2;
	localparam logic [1:0]  RESP_DEC  = 2'h3;

	typedef logic [15:0] fvp_word_t;

	function automatic fvp_word_t fvp_rst_val(input logic [4:0] ix);
		unique case (ix)
			IX_MAXF:   return 16'h04B0;
			IX_JOGF:   return 16'h0032;
			IX_STARTF: return 16'h0005;
			IX_JMP1A, IX_JMP1B, IX_JMP2A, IX_JMP2B,
			IX_JMP3A, IX_JMP3B, IX_BASEV, IX_BASE2F,
			IX_BOOST2: return CODE_OFF;
			IX_BASEF:  return 16'h0258;
			IX_BOOST:  return 16'h003C;
			IX_RATEDV: return 16'h00C8;
			IX_RATEDF: return 16'h0258;
			IX_ASTEP:  return 16'h0001;
			default:   return 16'h0000;
		endcase
	endfunction : fvp_rst_val

endpackage : fvp_pkg

//--- hw/fvp_top.sv
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

// Functional notes
// RL1: jog at or below minimum runs at jog frequency, not clamped up
// RL2: stall-driven decrease may take output to or below minimum
// RL3: start alone ramps to minimum if minimum is at least start frequency
// RL4: three jump bands, either edge setting may be upper or lower
// RL5: jump edges take 0..400 Hz; 9999, the reset value, disables band
// RL6: steady command inside a band runs at that band's A setting
// RL7: ramps pass straight through jump bands
// RL8: base frequency 0..400 Hz, resets to 60 Hz
// RL9: base voltage 0..1000 V; 8888 is 95% supply; 9999 is supply
// RL10: base voltage below supply caps maximum output voltage
// RL11: second-function input selects second base; 9999 disables it
// RL12: operator assigns function code 3 to a terminal to use it
// RL13: second-function input also enables the other second-set functions
// RL14: vector control uses motor rated voltage and frequency instead
// RL15: accel pattern 1 keeps base frequency as S-curve knee
// RL16: load pattern resets to 0; 0,1,2,3 encode the four curves
// RL17: pattern 0 gives voltage linear in frequency up to base
// RL18: pattern 1 gives voltage square-law in frequency up to base
// RL19: pattern 2 boosts forward, forces zero boost in reverse
// RL20: jump, base and pattern settings writable only when user group is 0
// RL21: command above maximum is clamped to maximum
// RL22: set frequency below minimum is clamped up to minimum
// RL23: limit, then jump, then curve, evaluated every update tick
module fvp_top (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic [fvp_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [fvp_pkg::AXI_DW-1:0] s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [fvp_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [fvp_pkg::AXI_DW-1:0]   s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [fvp_pkg::FW-1:0]  freq_cmd,
	input  wire logic                    start_pin,
	input  wire logic                    jog_pin,
	input  wire logic                    reverse_pin,
	input  wire logic                    stall_pin,
	input  wire logic                    second_function_select,
	input  wire logic [fvp_pkg::FW-1:0]  supply_volt,
	output logic [fvp_pkg::FW-1:0]       out_freq,
	output logic [fvp_pkg::FW-1:0]       out_volt,
	output logic [fvp_pkg::FW-1:0]       out_boost,
	output logic [fvp_pkg::FW-1:0]       knee_freq,
	output logic                         second_set_active,
	output logic                         ramping
);
	import fvp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic fvp_word_t fmin(input fvp_word_t a, input fvp_word_t b);
		return (a < b) ? a : b;
	endfunction : fmin

	function automatic fvp_word_t fmax(input fvp_word_t a, input fvp_word_t b);
		return (a > b) ? a : b;
	endfunction : fmax

	function automatic logic jump_hit(input fvp_word_t f, input fvp_word_t ja,
		input fvp_word_t jb);
		logic on;
		on = (ja != CODE_OFF) && (jb != CODE_OFF); // RL5
		return on && (f >= fmin(ja, jb)) && (f <= fmax(ja, jb)); // RL4
	endfunction : jump_hit

	function automatic logic freq_ok(input fvp_word_t v, input logic off_ok);
		return (v <= FREQ_LIM) || (off_ok && (v == CODE_OFF));
	endfunction : freq_ok

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	// a pin change reaches the logic two clocks late; the ramp hides it
	logic [4:0] pin_meta_ff;
	logic [4:0] pin_sync_ff;
	wire  [4:0] pin_raw = {second_function_select, stall_pin, reverse_pin,
		jog_pin, start_pin};

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin_meta_ff <= 5'h00;
			pin_sync_ff <= 5'h00;
		end else begin
			pin_meta_ff <= pin_raw;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	wire start_s  = pin_sync_ff[0];
	wire jog_s    = pin_sync_ff[1];
	wire rev_s    = pin_sync_ff[2];
	wire stall_s  = pin_sync_ff[3];
	wire second_s = pin_sync_ff[4];

	////////////////////////////////////////////////////////////////////////
	// register file and axi4-lite slave

	fvp_word_t  cfg_ff [NREG];
	logic       aw_have_ff;
	logic       w_have_ff;
	logic [IXW-1:0] aw_ix_ff;
	logic [AXI_DW-1:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic       bvalid_ff;
	logic [1:0] bresp_ff;
	logic       rvalid_ff;
	logic [AXI_DW-1:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [FW-1:0] ramp_ff;
	logic [FW-1:0] volt_ff;
	logic [FW-1:0] boost_ff;
	logic       ramping_ff;

	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = !w_have_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire wr_go   = aw_have_ff && w_have_ff && !bvalid_ff;
	wire [FW-1:0] wval = wdata_ff[FW-1:0];
	// a partial strobe would tear a 16-bit setting, so it is refused
	wire wr_full = (wstrb_ff[1:0] == 2'h3);
	wire wr_map  = (aw_ix_ff < IX_STFREQ);
	wire ugrp_open = (cfg_ff[IX_UGRP] == 16'h0000);

	// grouped settings are locked unless user group reads as zero
	logic grp_reg;
	always_comb begin
		unique case (aw_ix_ff)
			IX_MAXF, IX_MINF, IX_CTRL, IX_LOADP,
			IX_JMP1A, IX_JMP1B, IX_JMP2A, IX_JMP2B, IX_JMP3A, IX_JMP3B,
			IX_BASEF, IX_BASEV, IX_BASE2F: grp_reg = 1'b1;
			default: grp_reg = 1'b0;
		endcase
	end
	wire wr_locked = !ugrp_open && grp_reg; // RL20

	logic wr_legal;
	always_comb begin
		unique case (aw_ix_ff)
			IX_MAXF, IX_MINF: wr_legal = (wval <= LIMF_LIM);
			IX_JMP1A, IX_JMP1B, IX_JMP2A, IX_JMP2B, IX_JMP3A,
			IX_JMP3B, IX_BASE2F: wr_legal = freq_ok(wval, 1'b1); // RL5 RL11
			IX_BASEF, IX_JOGF, IX_STARTF, IX_RATEDF:
				wr_legal = freq_ok(wval, 1'b0); // RL8
			IX_BASEV: wr_legal = (wval <= VOLT_LIM) || (wval == CODE_95) ||
				(wval == CODE_OFF); // RL9
			IX_RATEDV: wr_legal = (wval <= VOLT_LIM);
			IX_LOADP: wr_legal = (wval <= {14'h0000, LP_LIFTR}); // RL16
			IX_BOOST: wr_legal = (wval <= BOOST_LIM);
			IX_BOOST2: wr_legal = (wval <= BOOST_LIM) || (wval == CODE_OFF);
			IX_CTRL: wr_legal = ((wval & ~CTRL_MASK) == 16'h0000);
			default: wr_legal = 1'b1;
		endcase
	end

	// a refused write still answers, so the master never waits in vain
	wire wr_do = wr_go && wr_map && wr_full && wr_legal && !wr_locked;
	wire [1:0] nxt_bresp = !wr_map ? RESP_DEC :
		(wr_do ? RESP_OK : RESP_SLV);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_ix_ff   <= 5'h00;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OK;
		end else begin
			if (aw_take) begin
				aw_have_ff <= 1'b1;
				aw_ix_ff   <= s_axi_awaddr[IX_LSB +: IXW];
			end
			if (w_take) begin
				w_have_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= nxt_bresp;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < NREG; i++) begin
			if (!rstn)
				cfg_ff[i] <= fvp_rst_val(5'(i));
			else if (wr_do && (aw_ix_ff == 5'(i)))
				cfg_ff[i] <= wval;
		end
	end

	// read side; unaligned low address bits are ignored
	wire [IXW-1:0] ar_ix = s_axi_araddr[IX_LSB +: IXW];
	wire ar_map = (ar_ix < 5'(NREG)) && (s_axi_araddr[AXI_AW-1] == 1'b0);
	wire [FW-1:0] st_flags = {11'h000, ramping_ff, stall_s, jog_s,
		second_s, start_s};
	wire [FW-1:0] rd_word = (ar_ix == IX_STFREQ) ? ramp_ff :
		(ar_ix == IX_STVOLT) ? volt_ff :
		(ar_ix == IX_STFLAG) ? st_flags : cfg_ff[ar_ix];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= ar_map ? {16'h0000, rd_word} : 32'h00000000;
			rresp_ff  <= ar_map ? RESP_OK : RESP_DEC;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frequency path: limit, jump, ramp

	wire [FW-1:0] maxf  = cfg_ff[IX_MAXF];
	wire [FW-1:0] minf  = cfg_ff[IX_MINF];
	wire [FW-1:0] jogf  = cfg_ff[IX_JOGF];
	wire [FW-1:0] stf   = cfg_ff[IX_STARTF];

	// jog wins over the minimum clamp, only the maximum applies to it
	wire [FW-1:0] jog_lim = fmin(jogf, maxf); // RL1
	wire [FW-1:0] cmd_hi  = fmin(freq_cmd, maxf); // RL21
	wire [FW-1:0] cmd_lim = fmax(cmd_hi, fmin(minf, maxf)); // RL22
	// with no command, a minimum at or above start frequency still runs
	wire [FW-1:0] run_f   = (cmd_lim >= stf) ? cmd_lim : 16'h0000; // RL3
	wire [FW-1:0] sel_f   = jog_s ? jog_lim : (start_s ? run_f : 16'h0000);

	// a band reaching down to zero must not start a stopped drive
	wire run_on = jog_s || start_s;
	wire hit1 = run_on &&
		jump_hit(sel_f, cfg_ff[IX_JMP1A], cfg_ff[IX_JMP1B]);
	wire hit2 = run_on &&
		jump_hit(sel_f, cfg_ff[IX_JMP2A], cfg_ff[IX_JMP2B]);
	wire hit3 = run_on &&
		jump_hit(sel_f, cfg_ff[IX_JMP3A], cfg_ff[IX_JMP3B]);
	wire [FW-1:0] target_f = hit1 ? cfg_ff[IX_JMP1A] :
		hit2 ? cfg_ff[IX_JMP2A] :
		hit3 ? cfg_ff[IX_JMP3A] : sel_f; // RL6 RL23

	logic [TCW-1:0] tick_ff;
	wire tick = (tick_ff == TCW'(UPD_CYC - 1));
	wire [TCW-1:0] nxt_tick = tick ? '0 : tick_ff + 1'b1;

	// ramp walks in steps through every frequency, jump bands included
	wire [FW-1:0] step    = fmax(cfg_ff[IX_ASTEP], 16'h0001);
	wire [FW-1:0] dn_f    = (ramp_ff > step) ? ramp_ff - step : 16'h0000;
	wire [FW-1:0] up_f    = ramp_ff + step;
	wire [FW-1:0] nxt_ramp = stall_s ? dn_f : // RL2
		(ramp_ff < target_f) ? fmin(up_f, target_f) :
		(ramp_ff > target_f) ? fmax(dn_f, target_f) : ramp_ff; // RL7

	always_ff @(posedge clk) begin
		if (!rstn)
			tick_ff <= '0;
		else
			tick_ff <= nxt_tick;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ramp_ff    <= 16'h0000;
			ramping_ff <= 1'b0;
		end else begin
			if (tick) begin
				ramp_ff    <= nxt_ramp; // RL23
				ramping_ff <= (nxt_ramp != target_f);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// v/f curve

	wire [1:0] mode   = cfg_ff[IX_CTRL][MODE_LSB +: 2];
	wire [1:0] apat   = cfg_ff[IX_CTRL][APAT_LSB +: 2];
	wire       vector = (mode != MODE_VF);
	wire [1:0] loadp  = cfg_ff[IX_LOADP][1:0];
	wire use2 = second_s && (cfg_ff[IX_BASE2F] != CODE_OFF); // RL11
	wire [FW-1:0] vf_base = use2 ? cfg_ff[IX_BASE2F] : cfg_ff[IX_BASEF];
	wire [FW-1:0] eff_bf  = vector ? cfg_ff[IX_RATEDF] : vf_base; // RL14

	// the two codes are not volts, so they bypass the supply clamp
	wire [FW-1:0] bv_set = cfg_ff[IX_BASEV];
	wire [31:0] sup95  = (32'(supply_volt) * 32'(PCT_95)) / 32'(PCT_DIV);
	wire [FW-1:0] bv_code = (bv_set == CODE_OFF) ? supply_volt :
		(bv_set == CODE_95) ? sup95[FW-1:0] :
		fmin(bv_set, supply_volt); // RL9 RL10
	wire [FW-1:0] eff_bv  = vector ?
		fmin(cfg_ff[IX_RATEDV], supply_volt) : bv_code; // RL14

	// ratio of frequency to base in 1/1024 steps, held at one above base
	// truncation may leave the voltage one step low
	wire [31:0] ratio_raw = (eff_bf == 16'h0000) ? 32'(1 << QSH) :
		(32'(ramp_f_q()) / 32'(eff_bf));
	wire [31:0] ratio  = (ratio_raw > 32'(1 << QSH)) ? 32'(1 << QSH) :
		ratio_raw;
	wire [31:0] v_lin  = (32'(eff_bv) * ratio) >> QSH; // RL17
	wire [31:0] v_sq   = (v_lin * ratio) >> QSH; // RL18
	wire        sq_on  = !vector && (loadp == LP_VAR);
	wire [FW-1:0] nxt_volt = sq_on ? v_sq[FW-1:0] : v_lin[FW-1:0];

	function automatic logic [31:0] ramp_f_q();
		return 32'(ramp_ff) << QSH;
	endfunction : ramp_f_q

	// second boost follows the second-set select when it is configured
	wire b2_on = second_s && (cfg_ff[IX_BOOST2] != CODE_OFF); // RL13
	wire [FW-1:0] boost_set = b2_on ? cfg_ff[IX_BOOST2] : cfg_ff[IX_BOOST];
	wire lift_fwd = (loadp == LP_LIFTF);
	wire lift_rev = (loadp == LP_LIFTR);
	// pattern 3 mirrors pattern 2: its driving side is reverse rotation
	wire boost_zero = !vector && ((lift_fwd && rev_s) ||
		(lift_rev && !rev_s)); // RL19 RL16
	wire [FW-1:0] nxt_boost = boost_zero ? 16'h0000 : boost_set;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			volt_ff  <= 16'h0000;
			boost_ff <= 16'h0000;
		end else if (tick) begin
			volt_ff  <= nxt_volt; // RL23
			boost_ff <= nxt_boost;
		end
	end

	// s-curve knee keeps the v/f base even under vector control
	wire [FW-1:0] nxt_knee = (apat == APAT_S_A) ? vf_base : eff_bf; // RL15
	logic [FW-1:0] knee_ff;
	logic          second_ff;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			knee_ff   <= 16'h0000;
			second_ff <= 1'b0;
		end else begin
			knee_ff   <= nxt_knee;
			second_ff <= second_s; // RL13
		end
	end

	assign out_freq          = ramp_ff;
	assign out_volt          = volt_ff;
	assign out_boost         = boost_ff;
	assign knee_freq         = knee_ff;
	assign second_set_active = second_ff;
	assign ramping           = ramping_ff;

endmodule : fvp_top

//--- bench/fvp_top_monitor.sv
`timescale 1ns/10ps
module fvp_top_monitor
	import fvp_pkg::*;
(
	input wire logic                      clk,
	input wire logic                      rstn,
	input wire logic                      s_axi_awready,
	input wire logic                      s_axi_wready,
	input wire logic [1:0]                s_axi_bresp,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire logic [fvp_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [fvp_pkg::AXI_DW-1:0] s_axi_rdata,
	input wire logic [1:0]                s_axi_rresp,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	input wire logic                      stall_pin,
	input wire logic                      second_function_select,
	input wire logic [fvp_pkg::FW-1:0]    out_freq,
	input wire logic [fvp_pkg::FW-1:0]    out_volt,
	input wire logic                      second_set_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	chk_ready_busy: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
	chk_dec_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_DEC
		|-> s_axi_rdata == 32'h0) else $error("decode error with data");
	chk_high_decode: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[7] |=> s_axi_rvalid && s_axi_rresp == RESP_DEC)
		else $error("high address not refused");
	chk_freq_cap: assert property (out_freq <= FREQ_LIM)
		else $error("output frequency above range");
	chk_freq_tick: assert property ($changed(out_freq)
		|=> $stable(out_freq) [*8]) else $error("frequency off tick");
	chk_volt_tick: assert property ($changed(out_volt)
		|=> $stable(out_volt) [*8]) else $error("voltage off tick");
	// five samples cover the two sync stages plus the output register
	chk_second_on: assert property (second_function_select [*5]
		|-> second_set_active) else $error("second set not active");
	chk_second_off: assert property (!second_function_select [*5]
		|-> !second_set_active) else $error("second set stuck");
	chk_stall_fall: assert property (stall_pin [*5]
		|-> out_freq <= $past(out_freq)) else $error("rising under stall");
endmodule : fvp_top_monitor
////////////////////////////////////////////////////////////////////////////
bind fvp_top fvp_top_monitor i_fvp_top_monitor (.clk(clk), .rstn(rstn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.stall_pin(stall_pin), .second_function_select(second_function_select),
	.out_freq(out_freq), .out_volt(out_volt),
	.second_set_active(second_set_active));

//--- bench/fvp_src_model.sv
`timescale 1ns/10ps
module fvp_src_model #(
	parameter logic [3:0] TERM_FN = 4'h3
) (
	input  wire logic        clk,
	input  wire logic [15:0] req_cmd,
	input  wire logic        req_sel,
	input  wire logic [15:0] req_supply,
	output logic      [15:0] freq_cmd,
	output logic             second_function_select,
	output logic      [15:0] supply_volt
);
	// the select terminal only reaches the drive once assigned code 3
	always_ff @(posedge clk) begin
		freq_cmd               <= req_cmd;
		second_function_select <= req_sel && TERM_FN == 4'h3;
		supply_volt            <= req_supply;
	end
endmodule : fvp_src_model

//--- bench/fvp_top_bench.sv
`timescale 1ns/10ps
module fvp_top_bench;
	import fvp_pkg::*;
	logic        clk, rstn, awv, wv, bry, arv, rry, st, jg, rv, sl, sel;
	logic        awr, wr_r, bv, arr, rvl, sec, rmp, prb;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rd;
	logic [1:0]  br, rr;
	logic [2:0]  pk;
	logic [15:0] cmd, sup, fc, sv, of, ov, ob, kf;
	logic [36:0] q[$];
	logic [31:0] rs;
	int          mismatches, samples_checked;
	fvp_top i_fvp_top (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rvl),
		.s_axi_rready(rry), .freq_cmd(fc), .start_pin(st), .jog_pin(jg),
		.reverse_pin(rv), .stall_pin(sl), .second_function_select(sec),
		.supply_volt(sv), .out_freq(of), .out_volt(ov), .out_boost(ob),
		.knee_freq(kf), .second_set_active(), .ramping(rmp));
	fvp_src_model i_fvp_src_model (.clk(clk), .req_cmd(cmd), .req_sel(sel),
		.req_supply(sup), .freq_cmd(fc), .second_function_select(sec),
		.supply_volt(sv));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [4:0] ix, input logic [15:0] v,
			input logic [1:0] e);
		logic ap, wp;
		ap = 1'b1;
		wp = 1'b1;
		q.push_back({3'h0, 32'h0, e});
		@(posedge clk);
		awa <= {1'b0, ix, 2'b00};
		wd  <= {16'h0, v};
		awv <= 1'b1;
		wv  <= 1'b1;
		bry <= 1'b1;
		while (ap || wp) begin
			@(posedge clk);
			if (ap && awr) begin
				awv <= 1'b0;
				ap = 1'b0;
			end
			if (wp && wr_r) begin
				wv <= 1'b0;
				wp = 1'b0;
			end
		end
		do @(posedge clk); while (bv !== 1'b1);
		bry <= 1'b0;
	endtask : wr
	task automatic rdx(input logic [7:0] a, input logic [33:0] e);
		q.push_back({3'h1, e});
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rvl !== 1'b1);
		rry <= 1'b0;
	endtask : rdx
	// fixed waits: the update tick is 100 cycles, 20 ticks settle any ramp
	task automatic pr(input logic [2:0] k, input logic [15:0] v);
		repeat (20 * UPD_CYC) @(posedge clk);
		q.push_back({k, 18'h0, v});
		pk  <= k;
		prb <= 1'b1;
		@(posedge clk);
		prb <= 1'b0;
	endtask : pr
	always @(posedge clk) begin : watch
		logic [36:0] n;
		logic [33:0] g;
		if ((bv && bry) || (rvl && rry) || prb) begin
			g = bv && bry ? {32'h0, br} : rvl && rry ? {rr, rd} :
				{18'h0, pk == 3'h2 ? of : pk == 3'h3 ? ov :
				pk == 3'h5 ? kf : pk == 3'h6 ? {15'h0, rmp} : ob};
			n = q.pop_front();
			samples_checked++;
			if (n[33:0] !== g) begin
				mismatches++;
				$display("[FAIL] %0t got %h expected %h", $time, g, n[33:0]);
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (80000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	initial begin
		{rstn, awv, wv, bry, arv, rry, st, jg, rv, sl, sel, prb} = '0;
		{awa, ara, wd, pk, cmd} = '0;
		sup = 16'h00C8;
		rs  = 32'h2C66;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rdx({1'b0, IX_MAXF, 2'b00}, {RESP_OK, 32'h04B0});
		rdx({1'b0, IX_JOGF, 2'b00}, {RESP_OK, 32'h0032});
		rdx({1'b0, IX_JMP3B, 2'b00}, {RESP_OK, 32'h270F});
		rdx({1'b0, IX_BASEF, 2'b00}, {RESP_OK, 32'h0258});
		rdx({1'b0, IX_BASEV, 2'b00}, {RESP_OK, 32'h270F});
		rdx({1'b0, IX_LOADP, 2'b00}, {RESP_OK, 32'h0000});
		rdx(8'h80, {RESP_DEC, 32'h0});
		rdx(8'h60, {RESP_DEC, 32'h0});
		wr(IX_STFREQ, 16'h0001, RESP_DEC);
		wr(IX_UGRP, 16'h0001, RESP_OK);
		wr(IX_BASEF, 16'h01F4, RESP_SLV);
		wr(IX_UGRP, 16'h0000, RESP_OK);
		rdx({1'b0, IX_BASEF, 2'b00}, {RESP_OK, 32'h0258});
		wr(IX_JMP1A, 16'h0FA1, RESP_SLV);
		wr(IX_ASTEP, 16'h0100, RESP_OK);
		st  <= 1'b1;
		cmd <= 16'h0258;
		pr(3'h2, 16'h0258);
		pr(3'h3, 16'h00C8);
		wr(IX_BASEV, CODE_95, RESP_OK);
		pr(3'h3, 16'h00BE);
		wr(IX_BASEV, 16'h0096, RESP_OK);
		pr(3'h3, 16'h0096);
		wr(IX_BASEV, CODE_OFF, RESP_OK);
		cmd <= 16'h012C;
		pr(3'h3, 16'h0064);
		wr(IX_JMP1A, 16'h012C, RESP_OK);
		wr(IX_JMP1B, 16'h00C8, RESP_OK);
		rs = xs(rs);
		cmd <= 16'h00D2 + 16'(rs % 80);
		pr(3'h2, 16'h012C);
		wr(IX_JMP1A, CODE_OFF, RESP_OK);
		wr(IX_JMP1B, CODE_OFF, RESP_OK);
		cmd <= 16'h07D0;
		pr(3'h2, 16'h04B0);
		wr(IX_MINF, 16'h0064, RESP_OK);
		cmd <= 16'h0000;
		pr(3'h2, 16'h0064);
		jg <= 1'b1;
		pr(3'h2, 16'h0032);
		jg <= 1'b0;
		sl <= 1'b1;
		pr(3'h2, 16'h0000);
		sl  <= 1'b0;
		sel <= 1'b1;
		wr(IX_LOADP, {14'h0000, LP_LIFTF}, RESP_OK);
		rv <= 1'b1;
		pr(3'h4, 16'h0000);
		rv  <= 1'b0;
		sel <= 1'b0;
		pr(3'h4, 16'h003C);
		cmd <= 16'h012C;
		wr(IX_LOADP, {14'h0000, LP_VAR}, RESP_OK);
		pr(3'h3, 16'h0032);
		pr(3'h6, 16'h0000);
		wr(IX_RATEDF, 16'h01F4, RESP_OK);
		wr(IX_CTRL, 16'h0005, RESP_OK);
		pr(3'h5, 16'h0258);
		wr(IX_CTRL, 16'h0001, RESP_OK);
		pr(3'h5, 16'h01F4);
		complete_run();
	end
endmodule : fvp_top_bench
